// file: ram_blk.sv
// Configurable synchronous RAM block with optional SECDED correction.
// Assumes user logic synchronous to clk_sys and an Avalon-MM master
// for the small control and status register set.
//
// The placing of the registers and the Avalon-MM interface to the registers were left to the implementer.
`timescale 1ns/1ns

// Function
// - Correction only in 64-bit simple dual-port large block
// - Fix one flipped bit, flag two
// - Three or more flips may misclassify
// - Three-bit status, registered or unregistered option
// - Registered status shares output clock and clear
// - Unregistered status ignores the clear
// - Status codes 000, 011, 101 only
// - No old-data collision result with correction on
// - Correction on: whole word always written
// - Medium and large blocks register every input
// - Small RAM offers flow-through read
// - Write with read disabled holds last read
// - Single-port collision: new, old or undefined
// - Depth by width options per block kind
// - Output register adds exactly one cycle
// - Simple dual-port: one write plus one read
// - Mixed widths only within one width class
// - Separate read and write enables, read low idles
// - Dual-port collision: old data or undefined
// - Small RAM: write enable only, never new data
module ram_blk
    import ram_blk_pkg::*;
#(
    parameter ram_blk_pkg::ram_kind_type  KIND      =
        ram_blk_pkg::large_ram_block,
    parameter ram_blk_pkg::port_mode_type MODE      =
        ram_blk_pkg::simple_dual_port,
    parameter int                         WR_W      = 64,
    parameter int                         RD_W      = 64,
    parameter int                         WR_DEPTH  = 2048,
    parameter bit                         ECC_EN    = 1'b1,
    parameter bit                         OUT_REG   = 1'b0,
    parameter bit                         ST_REG    = 1'b0,
    parameter bit                         FLOW_THRU = 1'b0,
    localparam int                        RD_DEPTH  =
        WR_DEPTH * WR_W / RD_W,
    localparam int                        WA_W      = $clog2(WR_DEPTH),
    localparam int                        RA_W      = $clog2(RD_DEPTH)
) (
    input  wire logic                                clk_sys,
    input  wire logic                                arst_n,
    input  wire logic                                ce,
    input  wire logic                                wr_en,
    input  wire logic [WA_W-1:0]                     wr_addr,
    input  wire logic [WR_W-1:0]                     wr_data,
    input  wire logic                                rd_en,
    input  wire logic [RA_W-1:0]                     rd_addr,
    output logic      [RD_W-1:0]                     rd_data,
    output logic      [2:0]                          ecc_status,
    input  wire logic [ram_blk_pkg::CSR_ADDR_W-1:0]  address,
    input  wire logic                                read,
    input  wire logic                                write,
    input  wire logic [ram_blk_pkg::CSR_DATA_W-1:0]  writedata,
    input  wire logic [ram_blk_pkg::CSR_BE_W-1:0]    byteenable,
    output logic      [ram_blk_pkg::CSR_DATA_W-1:0]  readdata,
    output logic                                     waitrequest
);
    import ram_blk_pkg::*;

    // Storage is kept in units of the narrower port width
    localparam int  U_W     = (WR_W < RD_W) ? WR_W : RD_W;
    localparam int  WR_U    = WR_W / U_W;
    localparam int  RD_U    = RD_W / U_W;
    localparam int  WR_SH   = $clog2(WR_U);
    localparam int  RD_SH   = $clog2(RD_U);
    localparam int  MAX_SH  = (WR_SH > RD_SH) ? WR_SH : RD_SH;
    localparam int  NUNITS  = WR_DEPTH * WR_U;
    localparam int  UA_W    = $clog2(NUNITS);
    localparam bit  IS_SMALL = (KIND == logic_array_ram);
    localparam bit  ECC_ON  = ECC_EN && KIND == large_ram_block &&
                              MODE == simple_dual_port &&
                              WR_W == ECC_DATA_W &&
                              RD_W == ECC_DATA_W;
    localparam int  STORE_W = ECC_ON ? ECC_CW_W : U_W;
    localparam bit  FLOW_ON = FLOW_THRU && IS_SMALL;
    localparam bit  CLASS_OK = (MODE == single_port) ? (WR_W == RD_W) :
        (width_class(WR_W) == width_class(RD_W) &&
         (width_class(WR_W) != CLASS_OTHER || WR_W == RD_W));
    localparam bit  CFG_OK  = CLASS_OK && geom_ok(KIND, WR_W, WR_DEPTH) &&
                              geom_ok(KIND, RD_W, RD_DEPTH);

    logic [STORE_W-1:0]    mem [NUNITS];
    logic [UA_W-1:0]       wr_ua;
    logic [UA_W-1:0]       rd_ua;
    logic                  overlap;
    logic                  rden_used;
    logic                  rd_fire;
    logic                  collide;
    logic [1:0]            rdw_req;
    logic [1:0]            rdw_eff;
    logic [RD_W-1:0]       old_word;
    logic [2:0]            old_st;
    logic [RD_W-1:0]       fresh_data;
    logic [2:0]            fresh_st;
    logic [RD_W-1:0]       lat_data;
    logic [2:0]            lat_st;
    logic [RD_W-1:0]       out_q;
    logic [2:0]            out_st_q;
    ctrl_type              ctrl_q;
    logic [2:0]            last_st_q;
    logic [CNT_W-1:0]      fix_cnt_q;
    logic [CNT_W-1:0]      dbl_cnt_q;
    logic                  ev_fix;
    logic                  ev_dbl;
    logic                  wait_q;
    logic [CSR_DATA_W-1:0] readdata_q;
    logic [CSR_DATA_W-1:0] csr_rd_word;
    logic [1:0]            csr_idx;
    logic                  bus_req;
    logic                  bus_acc;
    logic                  wr_ctrl;
    logic                  clr_cnt;

    // Address mapping and collision detect
    assign wr_ua = UA_W'(wr_addr) << WR_SH;
    assign rd_ua = (MODE == single_port) ? (UA_W'(wr_addr) << WR_SH) :
                                           (UA_W'(rd_addr) << RD_SH);
    assign overlap = (wr_ua >> MAX_SH) == (rd_ua >> MAX_SH);
    // Small RAM has no read enable; single port may leave it unused
    assign rden_used = !IS_SMALL &&
        (MODE == simple_dual_port || ctrl_q.use_rden);
    assign rd_fire = rden_used ? rd_en : 1'b1;
    // A single-port read always targets the word being written
    assign collide = wr_en && rd_fire && overlap;

    // Collision behaviour after block and mode restrictions
    assign rdw_req = ctrl_q.rdw;
    assign rdw_eff =
        (IS_SMALL && MODE == single_port) ? rdw_dont_care :
        (MODE == simple_dual_port && rdw_req == rdw_new_data) ?
            rdw_dont_care :
        (ECC_ON && rdw_req == rdw_old_data) ? rdw_dont_care :
        (rdw_req == rdw_old_data || rdw_req == rdw_new_data) ?
            rdw_req : rdw_dont_care;

    generate
        if (ECC_ON) begin : g_ecc
            ecc_result_type dec;
            assign dec      = ecc_decode(mem[rd_ua]);
            assign old_word = dec.data;
            assign old_st   = dec.status;
            always_ff @(posedge clk_sys) begin
                if (ce && wr_en) begin
                    mem[wr_ua] <= ecc_encode(wr_data);
                end
            end
        end else begin : g_plain
            for (genvar g = 0; g < RD_U; g++) begin : g_rd
                assign old_word[g*U_W +: U_W] =
                    mem[rd_ua + UA_W'(g)];
            end
            assign old_st = ECC_ST_NONE;
            always_ff @(posedge clk_sys) begin
                if (ce && wr_en) begin
                    for (int j = 0; j < WR_U; j++) begin
                        mem[wr_ua + UA_W'(j)] <= wr_data[j*U_W +: U_W];
                    end
                end
            end
        end
    endgenerate

    // Undefined collision result reads as all ones, status clean
    assign fresh_data = !collide ? old_word :
        (rdw_eff == rdw_new_data) ? RD_W'(wr_data) :
        (rdw_eff == rdw_old_data) ? old_word : '1;
    assign fresh_st = (collide && rdw_eff == rdw_dont_care) ?
        ECC_ST_NONE : old_st;

    // Output latch stage; flow-through skips it for the small RAM
    generate
        if (FLOW_ON) begin : g_flow
            assign lat_data = fresh_data;
            assign lat_st   = fresh_st;
        end else begin : g_latch
            logic [RD_W-1:0] lat_q;
            logic [2:0]      lat_st_q;
            always_ff @(posedge clk_sys or negedge arst_n) begin
                if (!arst_n) begin
                    lat_q <= '0;
                end else if (ce && rd_fire) begin
                    lat_q <= fresh_data;
                end
            end
            // Status straight from the decoder: no clear on this path
            always_ff @(posedge clk_sys) begin
                if (ce && rd_fire) begin
                    lat_st_q <= fresh_st;
                end
            end
            assign lat_data = lat_q;
            assign lat_st   = lat_st_q;
        end
    endgenerate

    // Optional output register stage, shared clear for data and status
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            out_q    <= '0;
            out_st_q <= ECC_ST_NONE;
        end else if (ce) begin
            out_q    <= lat_data;
            out_st_q <= lat_st;
        end
    end

    generate
        if (OUT_REG) begin : g_oreg
            assign rd_data = out_q;
        end else begin : g_ounreg
            assign rd_data = lat_data;
        end
        if (ST_REG) begin : g_sreg
            assign ecc_status = out_st_q;
        end else begin : g_sunreg
            assign ecc_status = lat_st;
        end
    endgenerate

    // Error event counters, saturating; a clear never hides an event
    assign ev_fix = ce && rd_fire && (fresh_st == ECC_ST_FIXED);
    assign ev_dbl = ce && rd_fire && (fresh_st == ECC_ST_DOUBLE);

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            fix_cnt_q <= '0;
            dbl_cnt_q <= '0;
            last_st_q <= ECC_ST_NONE;
        end else if (ce) begin
            if (clr_cnt) begin
                fix_cnt_q <= CNT_W'(ev_fix);
                dbl_cnt_q <= CNT_W'(ev_dbl);
            end else begin
                if (ev_fix && fix_cnt_q != '1)
                    fix_cnt_q <= fix_cnt_q + 1'b1;
                if (ev_dbl && dbl_cnt_q != '1)
                    dbl_cnt_q <= dbl_cnt_q + 1'b1;
            end
            if (rd_fire)
                last_st_q <= fresh_st;
        end
    end

    // Avalon-MM slave: one wait cycle, unmapped words read as zero
    assign bus_req = read || write;
    assign bus_acc = bus_req && !wait_q;
    assign csr_idx = address[CSR_ADDR_W-1:2];
    assign wr_ctrl = bus_acc && write && csr_idx == REG_CTRL_IDX &&
                     byteenable[0];
    assign clr_cnt = bus_acc && write && csr_idx == REG_ERRCNT_IDX;

    assign csr_rd_word =
        (csr_idx == REG_CTRL_IDX) ?
            CSR_DATA_W'({ctrl_q.use_rden, ctrl_q.rdw}) :
        (csr_idx == REG_STATUS_IDX) ?
            CSR_DATA_W'({last_st_q, ECC_ON, CFG_OK}) :
        (csr_idx == REG_ERRCNT_IDX) ?
            CSR_DATA_W'({dbl_cnt_q, fix_cnt_q}) : '0;

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            wait_q     <= 1'b1;
            readdata_q <= '0;
        end else if (ce) begin
            wait_q <= !(bus_req && wait_q);
            if (read && wait_q)
                readdata_q <= csr_rd_word;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            ctrl_q.rdw      <= CTRL_RDW_RESET;
            ctrl_q.use_rden <= CTRL_RDEN_RESET;
        end else if (ce && wr_ctrl) begin
            ctrl_q.rdw      <= writedata[CTRL_RDW_LSB +: 2];
            ctrl_q.use_rden <= writedata[CTRL_USE_RDEN];
        end
    end

    assign readdata    = readdata_q;
    assign waitrequest = wait_q;

endmodule

// file: ram_blk_pkg.sv
// Constants, types and helper functions of the embedded RAM block.
// Assumes one clock domain; shared by the block and its port checker.
package ram_blk_pkg;

    typedef enum logic [1:0] {
        logic_array_ram  = 2'b00,
        medium_ram_block = 2'b01,
        large_ram_block  = 2'b10
    } ram_kind_type;

    typedef enum logic {
        single_port      = 1'b0,
        simple_dual_port = 1'b1
    } port_mode_type;

    typedef enum logic [1:0] {
        rdw_dont_care = 2'b00,
        rdw_old_data  = 2'b01,
        rdw_new_data  = 2'b10
    } rdw_mode_type;

    // Correction code geometry
    localparam int ECC_DATA_W   = 64;
    localparam int ECC_CW_W     = 72;
    localparam int ECC_POS_BITS = 7;
    localparam logic [2:0] ECC_ST_NONE   = 3'h0;
    localparam logic [2:0] ECC_ST_FIXED  = 3'h3;
    localparam logic [2:0] ECC_ST_DOUBLE = 3'h5;

    // Geometry of each block kind
    localparam int PARITY_UNIT_W      = 9;
    localparam int SMALL_NARROW_MIN_W = 8;
    localparam int SMALL_NARROW_MAX_W = 10;
    localparam int SMALL_NARROW_DEPTH = 64;
    localparam int SMALL_WIDE_MIN_W   = 16;
    localparam int SMALL_WIDE_MAX_W   = 20;
    localparam int SMALL_WIDE_DEPTH   = 32;
    localparam int MED_MAX_W          = 36;
    localparam int MED_BITS           = 8192;
    localparam int MED_PAR_BITS       = 9216;
    localparam int LARGE_MIN_W        = 8;
    localparam int LARGE_BITS         = 131072;
    localparam int LARGE_PAR_BITS     = 147456;
    localparam int CLASS_POW2         = 0;
    localparam int CLASS_PARITY       = 1;
    localparam int CLASS_OTHER        = 2;

    // Register map (byte addresses, one word each)
    localparam int CSR_ADDR_W = 4;
    localparam int CSR_DATA_W = 32;
    localparam int CSR_BE_W   = 4;
    localparam logic [1:0] REG_CTRL_IDX   = 2'h0;
    localparam logic [1:0] REG_STATUS_IDX = 2'h1;
    localparam logic [1:0] REG_ERRCNT_IDX = 2'h2;
    localparam int CTRL_RDW_LSB     = 0;
    localparam int CTRL_USE_RDEN    = 2;
    localparam int STATUS_CFG_OK    = 0;
    localparam int STATUS_ECC_ON    = 1;
    localparam int STATUS_LAST_LSB  = 2;
    localparam int CNT_W            = 16;
    localparam int ERRCNT_DBL_LSB   = 16;
    localparam logic [1:0] CTRL_RDW_RESET  = 2'h0;
    localparam logic       CTRL_RDEN_RESET = 1'b1;

    typedef struct packed {
        logic [ECC_DATA_W-1:0] data;
        logic [2:0]            status;
    } ecc_result_type;

    typedef struct packed {
        logic [1:0] rdw;
        logic       use_rden;
    } ctrl_type;

    function automatic logic width_is_pow2(int w);
        return (w > 0) && ((w & (w - 1)) == 0);
    endfunction

    function automatic int width_class(int w);
        if (width_is_pow2(w) && w <= ECC_DATA_W)
            return CLASS_POW2;
        if ((w % PARITY_UNIT_W) == 0 && w <= ECC_CW_W &&
            width_is_pow2(w / PARITY_UNIT_W))
            return CLASS_PARITY;
        return CLASS_OTHER;
    endfunction

    function automatic logic geom_ok(ram_kind_type k, int w, int d);
        unique case (k)
            logic_array_ram: begin
                return (w >= SMALL_NARROW_MIN_W && w <= SMALL_NARROW_MAX_W
                        && d == SMALL_NARROW_DEPTH) ||
                       (w >= SMALL_WIDE_MIN_W && w <= SMALL_WIDE_MAX_W
                        && (w % 2) == 0 && d == SMALL_WIDE_DEPTH);
            end
            medium_ram_block: begin
                if (w > MED_MAX_W)
                    return 1'b0;
                if (width_class(w) == CLASS_POW2)
                    return d * w == MED_BITS;
                return width_class(w) == CLASS_PARITY && d * w == MED_PAR_BITS;
            end
            large_ram_block: begin
                if (w < LARGE_MIN_W)
                    return 1'b0;
                if (width_class(w) == CLASS_POW2)
                    return d * w == LARGE_BITS;
                return width_class(w) == CLASS_PARITY &&
                       d * w == LARGE_PAR_BITS;
            end
            default: return 1'b0;
        endcase
    endfunction

    // Hamming positions 1..71 with checks at powers of two, bit 0 overall
    function automatic logic [ECC_CW_W-1:0] ecc_encode(
        logic [ECC_DATA_W-1:0] d);
        logic [ECC_CW_W-1:0] c;
        int                  k;
        c = '0;
        k = 0;
        for (int p = 1; p < ECC_CW_W; p++) begin
            if ((p & (p - 1)) != 0) begin
                c[p] = d[k];
                k++;
            end
        end
        for (int i = 0; i < ECC_POS_BITS; i++) begin
            for (int p = 1; p < ECC_CW_W; p++) begin
                if (((p >> i) & 1) == 1 && p != (1 << i))
                    c[1 << i] = c[1 << i] ^ c[p];
            end
        end
        c[0] = ^c;
        return c;
    endfunction

    function automatic ecc_result_type ecc_decode(
        logic [ECC_CW_W-1:0] c_in);
        ecc_result_type          r;
        logic [ECC_CW_W-1:0]     c;
        logic [ECC_POS_BITS-1:0] syn;
        logic                    odd;
        int                      k;
        c = c_in;
        syn = '0;
        k = 0;
        for (int i = 0; i < ECC_POS_BITS; i++) begin
            for (int p = 1; p < ECC_CW_W; p++) begin
                if (((p >> i) & 1) == 1)
                    syn[i] = syn[i] ^ c[p];
            end
        end
        odd = ^c;
        r.status = ECC_ST_NONE;
        if (odd) begin
            // Syndrome beyond the word means three or more flips
            if (int'(syn) < ECC_CW_W) begin
                c[syn] = ~c[syn];
                r.status = ECC_ST_FIXED;
            end else begin
                r.status = ECC_ST_DOUBLE;
            end
        end else if (syn != '0) begin
            r.status = ECC_ST_DOUBLE;
        end
        r.data = '0;
        for (int p = 1; p < ECC_CW_W; p++) begin
            if ((p & (p - 1)) != 0) begin
                r.data[k] = c[p];
                k++;
            end
        end
        return r;
    endfunction

endpackage

// file: ram_blk_chk.sv
// Port checker for the RAM block: status codes, read data, slave wait.
// Assumes the default build: large block, simple dual port, ECC on.
`timescale 1ns/1ns
module ram_blk_chk
    import ram_blk_pkg::*;
#(
    parameter int  WR_W     = 64,
    parameter int  RD_W     = 64,
    parameter int  WR_DEPTH = 2048,
    localparam int WA_W     = $clog2(WR_DEPTH),
    localparam int RA_W     = $clog2(WR_DEPTH * WR_W / RD_W)
) (
    input wire logic              clk_sys,
    input wire logic              arst_n,
    input wire logic              ce,
    input wire logic              wr_en,
    input wire logic [WA_W-1:0]   wr_addr,
    input wire logic [WR_W-1:0]   wr_data,
    input wire logic              rd_en,
    input wire logic [RA_W-1:0]   rd_addr,
    input wire logic [RD_W-1:0]   rd_data,
    input wire logic [2:0]        ecc_status,
    input wire logic [3:0]        address,
    input wire logic              read,
    input wire logic              write,
    input wire logic [31:0]       readdata,
    input wire logic              waitrequest
);
    import ram_blk_pkg::*;
    logic seen_q;
    // Status is unknown until a read; no reset on purpose
    // Plain always: the start value comes from the initial block
    initial seen_q = 1'b0;
    always @(posedge clk_sys) seen_q <= seen_q | (ce & rd_en & arst_n);
    default clocking @(posedge clk_sys);
    endclocking
    default disable iff (!arst_n);
    property p_status_legal;
        ce && rd_en |=> ecc_status == ECC_ST_NONE ||
            ecc_status == ECC_ST_FIXED || ecc_status == ECC_ST_DOUBLE;
    endproperty
    a_status_legal: assert property (p_status_legal)
        else $error("illegal ecc status code");
    property p_collide;
        ce && rd_en && wr_en && rd_addr == wr_addr
            |=> rd_data == '1 && ecc_status == ECC_ST_NONE;
    endproperty
    a_collide: assert property (p_collide)
        else $error("collision read did not give the dont care word");
    property p_wr_rd;
        ce && wr_en && !rd_en ##1 ce && rd_en && !wr_en &&
            rd_addr == $past(wr_addr)
            |=> rd_data == $past(wr_data, 2) && ecc_status == ECC_ST_NONE;
    endproperty
    a_wr_rd: assert property (p_wr_rd)
        else $error("read one edge after write returned wrong word");
    property p_rd_hold;
        ce && !rd_en |=> $stable(rd_data) && (!seen_q || $stable(ecc_status));
    endproperty
    a_rd_hold: assert property (p_rd_hold)
        else $error("outputs moved without a read");
    property p_clear_keeps;
        disable iff (1'b0) seen_q && !arst_n |=> $stable(ecc_status);
    endproperty
    a_clear_keeps: assert property (p_clear_keeps)
        else $error("clear disturbed unregistered status");
    property p_wait_one;
        ce && (read || write) && waitrequest |=> !waitrequest ##1 waitrequest;
    endproperty
    a_wait_one: assert property (p_wait_one)
        else $error("slave did not answer after one wait cycle");
    property p_unmapped;
        read && address[3:2] == 2'h3 && !waitrequest |-> readdata == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped word did not read zero");
    property p_rdata_stands;
        !read |=> $stable(readdata);
    endproperty
    a_rdata_stands: assert property (p_rdata_stands)
        else $error("readdata changed without a read");
endmodule
bind ram_blk ram_blk_chk #(.WR_W(WR_W), .RD_W(RD_W), .WR_DEPTH(WR_DEPTH))
    ram_blk_chk_inst (.clk_sys, .arst_n, .ce, .wr_en, .wr_addr, .wr_data,
    .rd_en, .rd_addr, .rd_data, .ecc_status, .address, .read, .write,
    .readdata, .waitrequest);

// file: user_logic_model.sv
// Fabric user logic on the RAM port: one request set per clock.
// Assumes the bench calls cyc from one process only.
`timescale 1ns/1ns
module user_logic_model #(
    parameter int WA_W = 11,
    parameter int RA_W = 11,
    parameter int WR_W = 64
) (
    input  wire logic             clk_sys,
    output logic                  wr_en,
    output logic [WA_W-1:0]       wr_addr,
    output logic [WR_W-1:0]       wr_data,
    output logic                  rd_en,
    output logic [RA_W-1:0]       rd_addr
);
    initial begin
        wr_en = 1'h0;
        wr_addr = '0;
        wr_data = '0;
        rd_en = 1'h0;
        rd_addr = '0;
    end
    task automatic cyc(input logic we, input logic [WA_W-1:0] wa,
                       input logic [WR_W-1:0] wd, input logic re,
                       input logic [RA_W-1:0] ra);
        @(posedge clk_sys);
        wr_en <= we;
        wr_addr <= wa;
        // Unused write data and read address toggle so stale values never look valid
        wr_data <= we ? wd : ~wr_data;
        rd_en <= re;
        rd_addr <= re ? ra : ~rd_addr;
    endtask
endmodule

// file: embedded_ram_ecc_port_modes_bench.sv
// Bench for the RAM block in its default ECC build.
// Assumes user_logic_model on the RAM port; bench is the bus master.
`timescale 1ns/1ns
module embedded_ram_ecc_port_modes_bench;
    logic clk_sys, arst_n, ce, wr_en, rd_en, read, write, waitrequest;
    logic [10:0] wr_addr, rd_addr;
    logic [63:0] wr_data, rd_data;
    logic [2:0]  ecc_status;
    logic [3:0]  address, byteenable;
    logic [31:0] writedata, readdata;
    int          mismatches = 0;
    int          checked = 0;
    ram_blk ram_blk_inst (.clk_sys, .arst_n, .ce, .wr_en, .wr_addr,
        .wr_data, .rd_en, .rd_addr, .rd_data, .ecc_status, .address, .read,
        .write, .writedata, .byteenable, .readdata, .waitrequest);
    user_logic_model user_logic_model_inst (.clk_sys, .wr_en, .wr_addr,
        .wr_data, .rd_en, .rd_addr);
    function automatic logic [63:0] pat(input int i);
        return {32'hC0DE0000 + i, ~(32'h5A5A0000 + i)};
    endfunction
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic op(input logic we, input int wa, input logic [63:0] wd,
                      input logic re, input int ra);
        user_logic_model_inst.cyc(we, wa[10:0], wd, re, ra[10:0]);
    endtask
    task automatic bus(input logic w, input logic [3:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        @(posedge clk_sys);
        read <= ~w;
        write <= w;
        address <= a;
        writedata <= d;
        // Only the watchdog ends a wait that never completes
        do begin
            @(posedge clk_sys);
        end while (waitrequest !== 1'h0);
        q = readdata;
        read <= 1'h0;
        write <= 1'h0;
    endtask
    task automatic t_regs;
        logic [31:0] q;
        chk(rd_data, 64'h0);
        chk(waitrequest, 1'h1);
        bus(1'h0, 4'h0, 32'h0, q);
        chk(q, 32'h4);
        bus(1'h0, 4'h4, 32'h0, q);
        chk(q[1:0], 2'h3);
        bus(1'h0, 4'h8, 32'h0, q);
        chk(q, 32'h0);
        bus(1'h1, 4'hC, 32'hFFFFFFFF, q);
        bus(1'h0, 4'hC, 32'h0, q);
        chk(q, 32'h0);
    endtask
    task automatic t_rw;
        for (int i = 1; i < 5; i++) op(1'h1, i, pat(i), 1'h0, 0);
        op(1'h0, 0, 64'h0, 1'h1, 4);
        // Each read runs beside a write to another word
        for (int i = 3; i >= 0; i--) begin
            op(1'h1, i + 8, pat(i + 8), i > 0, i);
            @(negedge clk_sys);
            chk(rd_data, pat(i + 1));
            chk(ecc_status, 3'h0);
        end
    endtask
    task automatic t_hold;
        op(1'h0, 0, 64'h0, 1'h1, 9);
        op(1'h1, 9, pat(99), 1'h0, 0);
        op(1'h0, 0, 64'h0, 1'h0, 0);
        @(negedge clk_sys);
        chk(rd_data, pat(9));
        op(1'h0, 0, 64'h0, 1'h1, 9);
        op(1'h0, 0, 64'h0, 1'h0, 0);
        @(negedge clk_sys);
        chk(rd_data, pat(99));
    endtask
    task automatic t_collide;
        logic [31:0] q;
        for (int m = 0; m < 3; m++) begin
            bus(1'h1, 4'h0, 32'h4 | m, q);
            op(1'h1, 7, pat(m), 1'h1, 7);
            op(1'h0, 0, 64'h0, 1'h0, 0);
            @(negedge clk_sys);
            chk(rd_data, 64'hFFFFFFFFFFFFFFFF);
            chk(ecc_status, 3'h0);
        end
        bus(1'h0, 4'h4, 32'h0, q);
        chk(q[4:2], 3'h0);
        bus(1'h0, 4'h8, 32'h0, q);
        chk(q, 32'h0);
    endtask
    task automatic t_reset2;
        logic [31:0] q;
        @(posedge clk_sys);
        arst_n <= 1'h0;
        @(negedge clk_sys);
        chk(rd_data, 64'h0);
        chk(waitrequest, 1'h1);
        chk(ecc_status, 3'h0);
        repeat (2) @(posedge clk_sys);
        arst_n <= 1'h1;
        bus(1'h0, 4'h0, 32'h0, q);
        chk(q, 32'h4);
    endtask
    task automatic end_of_test;
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        clk_sys = 1'h0;
        forever #2 clk_sys = ~clk_sys;
    end
    initial begin
        arst_n = 1'h0;
        ce = 1'h1;
        {read, write, address, writedata} = '0;
        byteenable = 4'hF;
        repeat (4) @(posedge clk_sys);
        arst_n <= 1'h1;
        t_regs;
        t_rw;
        t_hold;
        t_collide;
        t_reset2;
        end_of_test;
    end
    // Whole run needs well under 200 cycles
    initial begin
        #4000;
        mismatches++;
        end_of_test;
    end
endmodule
